// ===== rtl/mib_core.sv
`timescale 1ns/10ps
module mib_core (
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic INSN_VALID,
   input wire logic [mib_pkg::INSN_W-1:0] INSN,
   input wire logic [mib_pkg::DATA_W-1:0] FILE_RDATA,
   input wire logic [mib_pkg::DATA_W-1:0] UPPER_ADDRESS_LATCH,
   output logic [mib_pkg::FADDR_W-1:0] FILE_ADDR,
   output logic FILE_WE,
   output logic [mib_pkg::DATA_W-1:0] FILE_WDATA,
   output logic [mib_pkg::DATA_W-1:0] ACC,
   output logic ZERO_FLAG,
   output logic [mib_pkg::PC_W-1:0] PC,
   output logic PC_LOAD,
   output logic SQUASH,
   output logic BUSY
);
   import mib_pkg::*;

   typedef struct packed {
      mib_state_e state;
      logic [DATA_W-1:0] acc;
      logic zero;
      logic [PC_W-1:0] pc;
      logic pc_load;
      logic squash;
      logic fwe;
      logic [FADDR_W-1:0] faddr;
      logic [DATA_W-1:0] fwdata;
   } mib_regs_s;

   // one bit per instruction class this block executes
   typedef enum logic [6:0] {
      MIB_OP_NONE = 7'b0000001,
      MIB_OP_MOVE = 7'b0000010,
      MIB_OP_INCR = 7'b0000100,
      MIB_OP_SKIP = 7'b0001000,
      MIB_OP_ORF = 7'b0010000,
      MIB_OP_ORL = 7'b0100000,
      MIB_OP_JUMP = 7'b1000000
   } mib_op_e;

   // operation codes understood by the arithmetic unit
   localparam logic [2:0] ALU_PASS = 3'h0;
   localparam logic [2:0] ALU_INCR = 3'h1;
   localparam logic [2:0] ALU_ORF = 3'h2;
   localparam logic [2:0] ALU_ORL = 3'h3;

   // unknown opcodes decode to none and leave all state alone
   function automatic mib_op_e decode_op(
      input logic [INSN_W-1:0] word
   );
      logic [5:0] op6;
      logic [3:0] op4;
      logic [2:0] op3;
      mib_op_e cls;
      op6 = word[INSN_W-1:OP6_LO];
      op4 = word[INSN_W-1:OP4_LO];
      op3 = word[INSN_W-1:OP3_LO];
      cls = MIB_OP_NONE;
      if (op6 == OPC_MOVE_FILE) begin
         cls = MIB_OP_MOVE;
      end else if (op6 == OPC_INCR_FILE) begin
         cls = MIB_OP_INCR;
      end else if (op6 == OPC_INCR_SKIP) begin
         cls = MIB_OP_SKIP;
      end else if (op6 == OPC_OR_FILE) begin
         cls = MIB_OP_ORF;
      end else if (op4 == OPC_OR_LIT) begin
         cls = MIB_OP_ORL;
      end else if (op3 == OPC_JUMP) begin
         cls = MIB_OP_JUMP;
      end
      return cls;
   endfunction : decode_op

   // classes that read a file register and honour the direction bit
   function automatic logic is_file_op(input mib_op_e cls);
      return (cls == MIB_OP_MOVE) || (cls == MIB_OP_INCR) ||
         (cls == MIB_OP_SKIP) || (cls == MIB_OP_ORF);
   endfunction : is_file_op

   // upper pc bits come from the latch, the rest from the operand
   function automatic logic [PC_W-1:0] jump_target(
      input logic [DATA_W-1:0] latch,
      input logic [INSN_W-1:0] word
   );
      return {latch[LATCH_HI:LATCH_LO], word[JUMP_W-1:0]};
   endfunction : jump_target

   // decode runs in the cycle the word is presented
   mib_regs_s r_ff;
   mib_regs_s nxt_r;
   mib_op_e op_cls;
   logic [2:0] alu_sel;
   logic [DATA_W-1:0] alu_res;
   logic alu_zero;
   logic dir;

   assign op_cls = decode_op(INSN);
   assign dir = INSN[DIR_BIT];
   // file address taken combinationally so the register file reads in time
   assign FILE_ADDR = INSN[FADDR_W-1:0];

   // move and jump pass the file value through; jump ignores the result
   always_comb begin
      alu_sel = ALU_PASS;
      unique case (op_cls)
         MIB_OP_INCR, MIB_OP_SKIP: alu_sel = ALU_INCR;
         MIB_OP_ORF: alu_sel = ALU_ORF;
         MIB_OP_ORL: alu_sel = ALU_ORL;
         MIB_OP_NONE, MIB_OP_MOVE, MIB_OP_JUMP: alu_sel = ALU_PASS;
      endcase
   end

   mib_alu u_alu (
      .op_sel(alu_sel),
      .acc(r_ff.acc),
      .fval(FILE_RDATA),
      .lit(INSN[DATA_W-1:0]),
      .result(alu_res),
      .is_zero(alu_zero)
   );

   // next-state logic: one instruction per cycle unless idle
   always_comb begin
      nxt_r = r_ff;
      // pulses last one cycle unless raised again below
      nxt_r.pc_load = 1'b0;
      nxt_r.squash = 1'b0;
      nxt_r.fwe = 1'b0;
      unique case (r_ff.state)
         MIB_EXEC: begin
            if (INSN_VALID) begin
               if (is_file_op(op_cls)) begin
                  nxt_r.faddr = INSN[FADDR_W-1:0];
                  if (dir) begin
                     nxt_r.fwe = 1'b1;
                     nxt_r.fwdata = alu_res;
                  end else begin
                     nxt_r.acc = alu_res;
                  end
               end
               unique case (op_cls)
                  MIB_OP_MOVE: begin
                     // with dir 1 the value is unchanged: a zero test
                     nxt_r.zero = alu_zero;
                  end
                  MIB_OP_INCR: begin
                     nxt_r.zero = alu_zero;
                  end
                  MIB_OP_SKIP: begin
                     // skip op leaves zero flag alone
                     if (alu_zero) begin
                        nxt_r.squash = 1'b1;
                        nxt_r.state = MIB_IDLE;
                     end
                  end
                  MIB_OP_ORF: begin
                     nxt_r.zero = alu_zero;
                  end
                  MIB_OP_ORL: begin
                     nxt_r.acc = alu_res;
                     nxt_r.zero = alu_zero;
                  end
                  MIB_OP_JUMP: begin
                     nxt_r.pc = jump_target(UPPER_ADDRESS_LATCH, INSN);
                     nxt_r.pc_load = 1'b1;
                     // flags stay; the idle cycle makes it two cycles
                     nxt_r.state = MIB_IDLE;
                  end
                  MIB_OP_NONE: begin
                     // unknown opcode: nothing changes
                  end
               endcase
            end
         end
         MIB_IDLE: begin
            // second cycle: fetched word is discarded, flags untouched
            nxt_r.state = MIB_EXEC;
         end
         default: nxt_r.state = MIB_EXEC;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         r_ff <= '{
            state: MIB_EXEC,
            acc: ACC_RST,
            zero: 1'b0,
            pc: PC_RST,
            pc_load: 1'b0,
            squash: 1'b0,
            fwe: 1'b0,
            faddr: '0,
            fwdata: ACC_RST
         };
      end else begin
         r_ff <= nxt_r;
      end
   end

   // outputs straight from the state register
   assign FILE_WE = r_ff.fwe;
   assign FILE_WDATA = r_ff.fwdata;
   assign ACC = r_ff.acc;
   assign ZERO_FLAG = r_ff.zero;
   assign PC = r_ff.pc;
   assign PC_LOAD = r_ff.pc_load;
   assign SQUASH = r_ff.squash;
   assign BUSY = (r_ff.state == MIB_IDLE);
endmodule : mib_core

// ===== rtl/mib_pkg.sv
package mib_pkg;
   localparam int unsigned INSN_W = 14;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FADDR_W = 7;
   localparam int unsigned PC_W = 13;
   localparam int unsigned JUMP_W = 11;
   localparam int unsigned LATCH_LO = 3;
   localparam int unsigned LATCH_HI = 4;
   // opcode field positions
   localparam int unsigned DIR_BIT = 7;
   localparam int unsigned OP6_LO = 8;
   localparam int unsigned OP3_LO = 11;
   localparam int unsigned OP4_LO = 10;
   // opcode encodings (upper six bits for file ops)
   localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
   localparam logic [5:0] OPC_INCR_FILE = 6'h0A;
   localparam logic [5:0] OPC_INCR_SKIP = 6'h0F;
   localparam logic [5:0] OPC_OR_FILE = 6'h04;
   localparam logic [3:0] OPC_OR_LIT = 4'hE;
   localparam logic [2:0] OPC_JUMP = 3'h5;
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   localparam logic [DATA_W-1:0] ONE = 8'h01;
   localparam logic [DATA_W-1:0] ZERO = 8'h00;

   typedef enum logic [1:0] {
      MIB_EXEC = 2'b01,
      MIB_IDLE = 2'b10
   } mib_state_e;
endpackage : mib_pkg

// ===== rtl/mib_alu.sv
`timescale 1ns/10ps
module mib_alu (
   input wire logic [2:0] op_sel,
   input wire logic [mib_pkg::DATA_W-1:0] acc,
   input wire logic [mib_pkg::DATA_W-1:0] fval,
   input wire logic [mib_pkg::DATA_W-1:0] lit,
   output logic [mib_pkg::DATA_W-1:0] result,
   output logic is_zero
);
   import mib_pkg::*;
   // op_sel: 0 move, 1 increment, 2 or-file, 3 or-literal
   always_comb begin
      unique case (op_sel)
         3'h1: result = fval + ONE;
         3'h2: result = acc | fval;
         3'h3: result = acc | lit;
         default: result = fval;
      endcase
      is_zero = (result == ZERO);
   end
endmodule : mib_alu

// ===== test/mib_chk_checker.sv
`timescale 1ns/10ps
module mib_chk import mib_pkg::*; (
   input logic CLK_SYS,
   input logic ARST_N,
   input logic INSN_VALID,
   input logic [13:0] INSN,
   input logic [7:0] FILE_RDATA,
   input logic [7:0] UPPER_ADDRESS_LATCH,
   input logic FILE_WE,
   input logic [7:0] ACC,
   input logic ZERO_FLAG,
   input logic [12:0] PC,
   input logic PC_LOAD,
   input logic SQUASH,
   input logic BUSY
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);
   wire tk = INSN_VALID & ~BUSY;
   wire mov = tk & (INSN[13:8] == OPC_MOVE_FILE);
   wire inc = tk & (INSN[13:8] == OPC_INCR_FILE);
   wire skp = tk & (INSN[13:8] == OPC_INCR_SKIP);
   wire orl = tk & (INSN[13:10] == OPC_OR_LIT);
   wire jmp = tk & (INSN[13:11] == OPC_JUMP);
   wire orf = tk & (INSN[13:8] == OPC_OR_FILE);
   sequence s_idle;
      BUSY && $stable(ZERO_FLAG) ##1 !BUSY;
   endsequence
   AST_DIR: assert property (mov |=> FILE_WE == $past(INSN[7]))
      else $error("dest");
   AST_SKIP: assert property (skp && FILE_RDATA == 8'hFF
      |=> SQUASH ##0 s_idle) else $error("skip");
   AST_NOSKIP: assert property (skp && FILE_RDATA != 8'hFF
      |=> !SQUASH) else $error("noskip");
   AST_JPC: assert property (jmp |=> PC ==
      {$past(UPPER_ADDRESS_LATCH[4:3]), $past(INSN[10:0])})
      else $error("pc");
   AST_JBUSY: assert property (jmp |=> PC_LOAD ##0 s_idle)
      else $error("jump");
   AST_DROP: assert property (BUSY |=> $stable(ACC) && !FILE_WE)
      else $error("drop");
   AST_ORL: assert property (orl |=>
      ACC == ($past(ACC) | $past(INSN[7:0]))) else $error("orl");
   AST_INC: assert property (inc |=> !SQUASH &&
      ZERO_FLAG == ($past(FILE_RDATA) == 8'hFF)) else $error("inc");
   AST_ORF: assert property (orf |=> ZERO_FLAG ==
      (($past(ACC) | $past(FILE_RDATA)) == 8'h00)) else $error("orf");
   AST_MOV: assert property (mov |=>
      ZERO_FLAG == ($past(FILE_RDATA) == 8'h00)) else $error("mov");
endmodule : mib_chk
bind mib_core mib_chk u_chk (.*);

// ===== test/test_mcu_incr_or_branch_exec.sv
`timescale 1ns/10ps
module test_mcu_incr_or_branch_exec;
   import mib_pkg::*;
   logic CLK_SYS = 0, ARST_N = 0, INSN_VALID = 0;
   logic [13:0] INSN = 0;
   logic [7:0] FILE_RDATA = 0, UPPER_ADDRESS_LATCH = 0, FILE_WDATA, ACC;
   logic [6:0] FILE_ADDR;
   logic [12:0] PC;
   logic FILE_WE, ZERO_FLAG, PC_LOAD, SQUASH, BUSY, z = 0;
   int error_cnt = 0, num_checks = 0, cyc = 0, k;
   logic [31:0] s = 47132, v;
   logic [7:0] acc = 0;
   logic [13:0] base [6] = '{14'h0800, 14'h0A00, 14'h0F00, 14'h0400,
      14'h3800, 14'h2800};
   mib_core uut (
      .CLK_SYS(CLK_SYS),
      .ARST_N(ARST_N),
      .INSN_VALID(INSN_VALID),
      .INSN(INSN),
      .FILE_RDATA(FILE_RDATA),
      .UPPER_ADDRESS_LATCH(UPPER_ADDRESS_LATCH),
      .FILE_ADDR(FILE_ADDR),
      .FILE_WE(FILE_WE),
      .FILE_WDATA(FILE_WDATA),
      .ACC(ACC),
      .ZERO_FLAG(ZERO_FLAG),
      .PC(PC),
      .PC_LOAD(PC_LOAD),
      .SQUASH(SQUASH),
      .BUSY(BUSY)
   );
   initial forever #2.5 CLK_SYS = ~CLK_SYS;
   function automatic logic [31:0] xs();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [7:0] exp_res(logic [13:0] i, logic [7:0] f,
      logic [7:0] a);
      if (i[13:10] == OPC_OR_LIT) return a | i[7:0];
      if (i[13:8] == OPC_OR_FILE) return a | f;
      if (i[13:8] == OPC_MOVE_FILE) return f;
      return f + 8'h01;
   endfunction : exp_res
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic test_done;
      if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   always @(posedge CLK_SYS) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic run(logic [13:0] i, logic [7:0] f);
      logic [7:0] u, r;
      logic lit, w, sk;
      u = 8'(xs());
      lit = i[13:10] == OPC_OR_LIT;
      @(posedge CLK_SYS);
      INSN <= i;
      FILE_RDATA <= f;
      UPPER_ADDRESS_LATCH <= u;
      INSN_VALID <= 1'b1;
      @(posedge CLK_SYS);
      INSN_VALID <= 1'b0;
      #1;
      if (i[13:11] == OPC_JUMP) begin
         chk("pc", {1'b1, u[4:3], i[10:0]}, {PC_LOAD, PC});
         chk("busy", 2'b10, {BUSY, SQUASH});
      end else begin
         r = exp_res(i, f, acc);
         if (i[13:8] != OPC_INCR_SKIP) z = r == 8'h00;
         w = i[7] & !lit;
         sk = i[13:8] == OPC_INCR_SKIP && r == 8'h00;
         if (!w) acc = r;
         chk("we", w, FILE_WE);
         if (w) chk("wdata", r, FILE_WDATA);
         chk("acc", acc, ACC);
         chk("zero", z, ZERO_FLAG);
         chk("faddr", i[6:0], FILE_ADDR);
         chk("skip", {sk, sk}, {SQUASH, BUSY});
      end
   endtask : run
   initial begin
      repeat (10) @(posedge CLK_SYS);
      chk("rst", 0, {ACC, ZERO_FLAG, PC_LOAD, SQUASH, BUSY});
      ARST_N <= 1'b1;
      run(14'h3800, 8'h00);
      run(14'h0F80, 8'hFF);
      run(14'h0F00, 8'hFF);
      run(14'h0A80, 8'hFF);
      run(14'h2FFF, 8'h00);
      // or-literal offered during the jump's idle cycle must be dropped
      @(posedge CLK_SYS);
      INSN <= 14'h2ABC;
      INSN_VALID <= 1'b1;
      @(posedge CLK_SYS);
      INSN <= 14'h38FF;
      @(posedge CLK_SYS);
      INSN_VALID <= 1'b0;
      #1;
      chk("drop", {acc, z}, {ACC, ZERO_FLAG});
      repeat (300) begin
         k = int'(xs() % 6);
         v = xs();
         run(base[k] | (v[13:0] & (k == 5 ? 14'h07FF : 14'h00FF)),
            v[19:16] == 0 ? 8'hFF : v[31:24]);
      end
      test_done();
   end
endmodule : test_mcu_incr_or_branch_exec
